// >>> rtl/fault_mon_pkg.sv
// Shared constants for the safety input fault monitor
package fault_mon_pkg;
  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] OFS_FAULT_STATUS = 8'h00;
  localparam logic [7:0] OFS_FAULT_MASK = 8'h04;
  localparam logic [7:0] OFS_LIMIT_ONE = 8'h08;
  localparam logic [7:0] OFS_LIMIT_TWO = 8'h0c;
  localparam logic [7:0] OFS_LIMIT_THREE = 8'h10;
  localparam logic [7:0] OFS_LIMIT_FOUR = 8'h14;
  localparam logic [7:0] OFS_LIMIT_FIVE = 8'h18;
  localparam logic [7:0] OFS_FILTER_SETTING = 8'h1c;
  localparam logic [7:0] OFS_CONTROL = 8'h20;
  localparam logic [7:0] OFS_LIVE_STATE = 8'h24;
  localparam logic [7:0] OFS_FAULT_CODE = 8'h28;

  // Fault status bit positions
  localparam int FLT_INPUT_ONE = 0;
  localparam int FLT_INPUT_FIVE = 4;
  localparam int FLT_RAIL = 5;
  localparam int FLT_SELF_TEST = 6;
  localparam int FLT_TASK = 7;
  localparam int FLT_TORQUE_OFF = 8;
  localparam int FLT_SINGLE_CH = 9;
  localparam int FLT_BUF_SUPPLY = 10;
  localparam int FLT_COUPLER = 11;
  localparam int FLT_BUF_INIT = 12;
  localparam int FLT_NOISE = 13;
  localparam int NUM_FAULTS = 14;

  // Control register bit
  localparam int CTL_FAULT_RESET = 0;

  // Live state bit positions
  localparam int LIVE_TORQUE_OFF = 0;
  localparam int LIVE_PWM_BLOCK = 1;
  localparam int LIVE_CH_A = 2;
  localparam int LIVE_CH_B = 3;
  localparam int LIVE_INIT_DONE = 4;

  // Reset values
  localparam logic [NUM_FAULTS-1:0] FAULT_MASK_RST = 14'h3fff;
  localparam logic [15:0] LIMIT_RST = 16'h0064;
  localparam logic [7:0] FILTER_RST = 8'h0a;

  // Fault codes, reported as packed decimal digits
  localparam logic [15:0] CODE_NONE = 16'h0000;
  localparam logic [15:0] CODE_INPUT_BASE = 16'h1341;
  localparam logic [15:0] CODE_RAIL = 16'h1350;
  localparam logic [15:0] CODE_SELF_TEST = 16'h1450;
  localparam logic [15:0] CODE_TASK = 16'h1451;
  localparam logic [15:0] CODE_TORQUE_OFF = 16'h1500;
  localparam logic [15:0] CODE_SINGLE_CH = 16'h1501;
  localparam logic [15:0] CODE_BUF_SUPPLY = 16'h1502;
  localparam logic [15:0] CODE_COUPLER = 16'h1503;
  localparam logic [15:0] CODE_BUF_INIT = 16'h1504;
  localparam logic [15:0] CODE_NOISE = 16'h1505;

  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int TASK_PERIOD_NS = 62500;
  localparam int TASK_TIMEOUT_CYC = (2 * TASK_PERIOD_NS) / CLK_PERIOD_NS;
  localparam int BUF_TEST_NS = 10000;
  localparam int BUF_TEST_CYC = BUF_TEST_NS / CLK_PERIOD_NS;
  localparam logic [15:0] SINGLE_CH_LIMIT = 16'h000a;
  localparam int NOISE_EDGES = 4;
endpackage

// >>> rtl/channel_mismatch.sv
// Dual-channel mismatch timer with single-shot fault pulse
`timescale 1ns/100ps
module channel_mismatch
  import fault_mon_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // synchronised reset
  input wire logic tick, // 1 us enable
  input wire logic ch_a, // channel A level
  input wire logic ch_b, // channel B level
  input wire logic [CNT_W-1:0] limit, // allowed mismatch in ticks
  output logic fault // one-cycle pulse on overrun
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic tripped;
    logic fault;
  } mm_state_t;

  mm_state_t st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    st_next.fault = 1'b0;
    if (ch_a == ch_b) begin
      st_next.cnt = '0; // [R13]
      st_next.tripped = 1'b0; // [R13]
    end else if (tick && !st_reg.tripped) begin
      if (st_reg.cnt >= limit) begin
        st_next.fault = 1'b1; // [R1] [R2]
        st_next.tripped = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign fault = st_reg.fault;
endmodule // channel_mismatch

// >>> rtl/torque_off_filter.sv
// Noise filter for one safe torque off channel
`timescale 1ns/100ps
module torque_off_filter
  import fault_mon_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // synchronised reset
  input wire logic tick, // 1 us enable
  input wire logic raw, // unfiltered channel level
  input wire logic [7:0] setting, // quiet time in ticks
  output logic filtered, // accepted level
  output logic noise // one-cycle pulse on too many edges
);
  typedef struct packed {
    logic prev;
    logic stable;
    logic [7:0] quiet;
    logic [2:0] edges;
    logic noise;
  } flt_state_t;

  flt_state_t st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    st_next.noise = 1'b0;
    st_next.prev = raw;
    if (raw != st_reg.prev) begin
      st_next.quiet = '0;
      if (st_reg.edges == 3'(NOISE_EDGES - 1)) begin
        st_next.noise = 1'b1; // [R12]
        st_next.edges = '0;
      end else begin
        st_next.edges = st_reg.edges + 1'b1;
      end
    end else if (st_reg.quiet >= setting) begin
      st_next.stable = raw; // [R12]
      st_next.edges = '0;
    end else if (tick) begin
      st_next.quiet = st_reg.quiet + 1'b1;
    end
  end

  // Reset value is "channel removed", so the drive starts in torque off
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign filtered = st_reg.stable;
  assign noise = st_reg.noise;
endmodule // torque_off_filter

// >>> rtl/safety_input_fault_monitor.sv
// Fault supervision of safety inputs, torque off channels and self-tests
//
// Operation
// (R1) Input five mismatch longer than its limit raises its discrepancy fault.
// (R2) Inputs one to four are supervised alike, each with its own limit.
// (R3) Partner chip supply flagged outside 3.0 V to 3.6 V raises rail fault.
// (R4) Processor, RAM, flash self-test failure or stack overflow raises self-test fault.
// (R5) Missing periodic 16 kHz safety task raises execution fault.
// (R6) Loss of either 24 V torque off channel enters torque off and reports it.
// (R7) Torque off clears only by fault reset; host resets after inputs recover.
// (R8) Only one torque off channel present raises single-channel fault.
// (R9) Gate buffer 5 V over or undervoltage raises buffer supply fault.
// (R10) Shorted isolation coupler before torque off inputs raises coupler fault.
// (R11) Power-on test that gate buffer blocks PWM; failure raises init fault.
// (R12) Torque off inputs are noise filtered; excessive toggling raises noise fault.
// (R13) Mismatch timer restarts whenever the two channels agree again.
// (R14) While torque off is active the gate buffer is held blocked.
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
module safety_input_fault_monitor
  import fault_mon_pkg::*;
#(
  parameter int TASK_TIMEOUT = TASK_TIMEOUT_CYC,
  parameter int NUM_INPUTS = 5
) (
  input wire logic clk_sys, // 200 MHz system clock
  input wire logic nrst, // asynchronous active-low reset
  input wire logic [7:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, cycle after strobe
  input wire logic [NUM_INPUTS-1:0] input_ch_a, // safety inputs, channel A
  input wire logic [NUM_INPUTS-1:0] input_ch_b, // safety inputs, channel B
  input wire logic torque_off_ch_a, // safe torque off channel A, 1 = 24 V present
  input wire logic torque_off_ch_b, // safe torque off channel B, 1 = 24 V present
  input wire logic rail_out_of_range, // partner 3.3 V rail outside window
  input wire logic cpu_test_fail, // processor self-test failed
  input wire logic ram_test_fail, // RAM self-test failed
  input wire logic flash_test_fail, // flash self-test failed
  input wire logic stack_overflow, // stack overflow detected
  input wire logic task_beat, // pulse per executed 16 kHz task
  input wire logic buf_supply_bad, // gate buffer 5 V out of range
  input wire logic coupler_short, // coupler short diagnostic
  input wire logic buf_blocked_fb, // gate buffer reports outputs blocked
  output logic pwm_block, // block gate buffer, high = blocked
  output logic torque_off_active, // safe torque off state
  output logic [15:0] fault_code, // highest-priority active fault code
  output logic irq // level interrupt
);
  typedef enum logic [1:0] {
    INIT_TEST = 2'b01,
    INIT_DONE = 2'b10
  } init_state_t;

  typedef struct packed {
    logic [NUM_FAULTS-1:0] status;
    logic [NUM_FAULTS-1:0] mask;
    logic [NUM_INPUTS-1:0][15:0] limit;
    logic [7:0] filter_set;
    logic [31:0] rdata;
    logic [$clog2(TICK_CYC)-1:0] tick_cnt;
    logic tick;
    logic [$clog2(TASK_TIMEOUT+1)-1:0] task_cnt;
    logic task_lost;
    init_state_t init_st;
    logic [$clog2(BUF_TEST_CYC+1)-1:0] init_cnt;
    logic sto;
    logic [15:0] code;
  } mon_state_t;

  mon_state_t st_reg, st_next;
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [NUM_INPUTS-1:0] input_fault;
  logic filt_a, filt_b, noise_a, noise_b, single_fault;
  logic [NUM_FAULTS-1:0] events;
  logic wr_status, wr_control;

  // Highest bit wins, so a pending input fault never hides torque off
  function automatic logic [15:0] encode_fault(input logic [NUM_FAULTS-1:0] f);
    logic [15:0] c;
    c = CODE_NONE;
    for (int i = 0; i < NUM_FAULTS; i++) begin
      if (f[i]) begin
        case (i)
          FLT_RAIL: c = CODE_RAIL;
          FLT_SELF_TEST: c = CODE_SELF_TEST;
          FLT_TASK: c = CODE_TASK;
          FLT_TORQUE_OFF: c = CODE_TORQUE_OFF;
          FLT_SINGLE_CH: c = CODE_SINGLE_CH;
          FLT_BUF_SUPPLY: c = CODE_BUF_SUPPLY;
          FLT_COUPLER: c = CODE_COUPLER;
          FLT_BUF_INIT: c = CODE_BUF_INIT;
          FLT_NOISE: c = CODE_NOISE;
          default: c = CODE_INPUT_BASE + 16'(i);
        endcase
      end
    end
    return c;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // Reset release through two flops, assertion stays asynchronous
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_input
      channel_mismatch #(.CNT_W(16)) u_mismatch (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .tick(st_reg.tick),
        .ch_a(input_ch_a[gi]),
        .ch_b(input_ch_b[gi]),
        .limit(st_reg.limit[gi]),
        .fault(input_fault[gi]) // [R1] [R2]
      );
    end
  endgenerate

  torque_off_filter u_filter_a (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tick(st_reg.tick),
    .raw(torque_off_ch_a),
    .setting(st_reg.filter_set),
    .filtered(filt_a),
    .noise(noise_a)
  );

  torque_off_filter u_filter_b (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tick(st_reg.tick),
    .raw(torque_off_ch_b),
    .setting(st_reg.filter_set),
    .filtered(filt_b),
    .noise(noise_b)
  );

  // Channels disagreeing past a short limit means one channel is dead
  channel_mismatch #(.CNT_W(16)) u_single (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tick(st_reg.tick),
    .ch_a(filt_a),
    .ch_b(filt_b),
    .limit(SINGLE_CH_LIMIT),
    .fault(single_fault) // [R8]
  );

  assign wr_status = reg_wr && hit(reg_addr, OFS_FAULT_STATUS);
  assign wr_control = reg_wr && hit(reg_addr, OFS_CONTROL);

  always_comb begin
    events = '0;
    events[FLT_INPUT_FIVE:FLT_INPUT_ONE] = input_fault; // [R1] [R2]
    events[FLT_RAIL] = rail_out_of_range; // [R3]
    events[FLT_SELF_TEST] = cpu_test_fail | ram_test_fail
                            | flash_test_fail | stack_overflow; // [R4]
    events[FLT_TASK] = st_reg.task_lost; // [R5]
    events[FLT_TORQUE_OFF] = st_reg.sto; // [R6]
    events[FLT_SINGLE_CH] = single_fault; // [R8]
    events[FLT_BUF_SUPPLY] = buf_supply_bad; // [R9]
    events[FLT_COUPLER] = coupler_short; // [R10]
    events[FLT_BUF_INIT] = 1'b0;
    events[FLT_NOISE] = noise_a | noise_b; // [R12]
  end

  always_comb begin
    st_next = st_reg;

    // 1 us tick divider
    st_next.tick = 1'b0;
    if (st_reg.tick_cnt == ($clog2(TICK_CYC))'(TICK_CYC - 1)) begin
      st_next.tick_cnt = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + 1'b1;
    end

    // Safety task watchdog: two missed periods count as not executed
    st_next.task_lost = 1'b0;
    if (task_beat) begin
      st_next.task_cnt = '0;
    end else if (st_reg.task_cnt == ($clog2(TASK_TIMEOUT+1))'(TASK_TIMEOUT)) begin
      st_next.task_lost = 1'b1; // [R5]
      st_next.task_cnt = '0;
    end else begin
      st_next.task_cnt = st_reg.task_cnt + 1'b1;
    end

    // Power-on blocking test of the gate buffer
    case (st_reg.init_st)
      INIT_TEST: begin
        if (st_reg.init_cnt == ($clog2(BUF_TEST_CYC+1))'(BUF_TEST_CYC)) begin
          st_next.init_st = INIT_DONE;
        end else begin
          st_next.init_cnt = st_reg.init_cnt + 1'b1;
        end
      end
      INIT_DONE: begin
        st_next.init_cnt = st_reg.init_cnt;
      end
      default: begin
        st_next.init_st = INIT_TEST;
      end
    endcase

    // Torque off: entered on any channel loss, left only by fault reset
    if (!filt_a || !filt_b) begin
      st_next.sto = 1'b1; // [R6]
    end else if (wr_control && reg_wdata[CTL_FAULT_RESET]) begin
      st_next.sto = 1'b0; // [R7]
    end

    // Sticky status; a new event beats a write-one clear
    if (wr_status) begin
      st_next.status = st_reg.status & ~reg_wdata[NUM_FAULTS-1:0];
    end
    st_next.status = st_next.status | events;
    if (!st_next.sto) begin
      st_next.status[FLT_TORQUE_OFF] = st_next.status[FLT_TORQUE_OFF]
                                       & ~(wr_control && reg_wdata[CTL_FAULT_RESET]);
    end else begin
      st_next.status[FLT_TORQUE_OFF] = 1'b1; // [R7]
    end
    if (st_reg.init_st == INIT_TEST
        && st_reg.init_cnt == ($clog2(BUF_TEST_CYC+1))'(BUF_TEST_CYC)
        && !buf_blocked_fb) begin
      st_next.status[FLT_BUF_INIT] = 1'b1; // [R11]
    end

    // Configuration writes
    if (reg_wr) begin
      case (reg_addr)
        OFS_FAULT_MASK: st_next.mask = reg_wdata[NUM_FAULTS-1:0];
        OFS_LIMIT_ONE: st_next.limit[0] = reg_wdata[15:0];
        OFS_LIMIT_TWO: st_next.limit[1] = reg_wdata[15:0];
        OFS_LIMIT_THREE: st_next.limit[2] = reg_wdata[15:0];
        OFS_LIMIT_FOUR: st_next.limit[3] = reg_wdata[15:0];
        OFS_LIMIT_FIVE: st_next.limit[NUM_INPUTS-1] = reg_wdata[15:0];
        OFS_FILTER_SETTING: st_next.filter_set = reg_wdata[7:0];
        default: st_next.mask = st_next.mask;
      endcase
    end

    st_next.code = encode_fault(st_next.status);

    // Read data stands for one cycle only
    st_next.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        OFS_FAULT_STATUS: st_next.rdata = 32'(st_reg.status);
        OFS_FAULT_MASK: st_next.rdata = 32'(st_reg.mask);
        OFS_LIMIT_ONE: st_next.rdata = 32'(st_reg.limit[0]);
        OFS_LIMIT_TWO: st_next.rdata = 32'(st_reg.limit[1]);
        OFS_LIMIT_THREE: st_next.rdata = 32'(st_reg.limit[2]);
        OFS_LIMIT_FOUR: st_next.rdata = 32'(st_reg.limit[3]);
        OFS_LIMIT_FIVE: st_next.rdata = 32'(st_reg.limit[NUM_INPUTS-1]);
        OFS_FILTER_SETTING: st_next.rdata = 32'(st_reg.filter_set);
        OFS_LIVE_STATE: begin
          st_next.rdata[LIVE_TORQUE_OFF] = st_reg.sto;
          st_next.rdata[LIVE_PWM_BLOCK] = pwm_block;
          st_next.rdata[LIVE_CH_A] = filt_a;
          st_next.rdata[LIVE_CH_B] = filt_b;
          st_next.rdata[LIVE_INIT_DONE] = (st_reg.init_st == INIT_DONE);
        end
        OFS_FAULT_CODE: st_next.rdata = 32'(st_reg.code);
        default: st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.mask <= FAULT_MASK_RST;
      st_reg.limit <= {NUM_INPUTS{LIMIT_RST}};
      st_reg.filter_set <= FILTER_RST;
      st_reg.init_st <= INIT_TEST;
      st_reg.sto <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Buffer blocked during the init test, in torque off, and while the FLT_BUF_INIT status bit from a failed test is set
  assign pwm_block = st_reg.sto || (st_reg.init_st == INIT_TEST)
                     || st_reg.status[FLT_BUF_INIT]; // [R14] [R11]
  assign torque_off_active = st_reg.sto;
  assign fault_code = st_reg.code;
  assign reg_rdata = st_reg.rdata;
  assign irq = |(st_reg.status & st_reg.mask);
endmodule // safety_input_fault_monitor

// >>> tb/fault_mon_checker.sv
// Port-level assertions for the safety input fault monitor
`timescale 1ns/100ps
module fault_mon_checker
  import fault_mon_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic nrst, // reset, active low
  input wire logic [7:0] reg_addr, // register address
  input wire logic [31:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [31:0] reg_rdata, // read data
  input wire logic torque_off_ch_a, // torque off channel A
  input wire logic torque_off_ch_b, // torque off channel B
  input wire logic pwm_block, // gate buffer block
  input wire logic torque_off_active, // torque off state
  input wire logic [15:0] fault_code, // reported fault code
  input wire logic irq // level interrupt
);
  logic [11:0] up_reg;
  logic ctl_wr;
  // Saturating age since reset, enough to cover the buffer test
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      up_reg <= 12'h000;
    end else if (up_reg != 12'hfff) begin
      up_reg <= up_reg + 12'h001;
    end
  end
  assign ctl_wr = reg_wr && reg_addr == OFS_CONTROL && reg_wdata[CTL_FAULT_RESET];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sto_blocks_a: assert property (torque_off_active |-> pwm_block)
    else $error("gate buffer open in torque off");
  init_block_a: assert property (up_reg < BUF_TEST_CYC |-> pwm_block)
    else $error("gate buffer open during power-on test");
  sto_code_a: assert property ((up_reg > 12'h010 && torque_off_active) [*3]
    |-> fault_code >= CODE_TORQUE_OFF) else $error("torque off not reported");
  clear_cmd_a: assert property ($fell(torque_off_active)
    |-> $past(ctl_wr) || $past(ctl_wr, 2)) else $error("torque off left without reset");
  clear_chan_a: assert property ($fell(torque_off_active)
    |-> $past(torque_off_ch_a && torque_off_ch_b, 2)) else $error("torque off left, supply lost");
  idle_rdata_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
  unmapped_rd_a: assert property (reg_rd && reg_addr > OFS_FAULT_CODE |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  irq_code_a: assert property (irq |-> ##[0:1] fault_code != CODE_NONE)
    else $error("interrupt without fault code");
  cover property ($fell(torque_off_active));
  cover property ($rose(irq));
  cover property (reg_rd && reg_addr > OFS_FAULT_CODE);
endmodule // fault_mon_checker

// >>> tb/sto_terminal_model.sv
// Torque off terminal model: two 24 V channels, channel A may bounce
`timescale 1ns/100ps
module sto_terminal_model (
  input wire logic clk_sys, // system clock
  input wire logic drop_a, // remove channel A supply
  input wire logic drop_b, // remove channel B supply
  input wire logic chatter, // bounce channel A
  output logic torque_off_ch_a, // channel A level
  output logic torque_off_ch_b // channel B level
);
  logic [4:0] div_reg = 5'h00;
  logic bounce_reg = 1'b1;
  always_ff @(posedge clk_sys) begin
    div_reg <= div_reg + 5'h01;
    if (!chatter) begin
      bounce_reg <= 1'b1;
    end else if (div_reg == 5'h00) begin
      bounce_reg <= !bounce_reg;
    end
  end
  // Removed supply reads low: the input stage has a pull-down
  assign torque_off_ch_a = !drop_a && bounce_reg;
  assign torque_off_ch_b = !drop_b;
endmodule // sto_terminal_model

// >>> tb/safety_input_fault_monitor_test.sv
// Self-checking bench for the safety input fault monitor
`timescale 1ns/100ps
module safety_input_fault_monitor_test;
  import fault_mon_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [4:0] in_a = 5'h00;
  logic [4:0] in_b = 5'h00;
  logic drop_a = 1'b0;
  logic drop_b = 1'b0;
  logic chatter = 1'b0;
  logic ch_a;
  logic ch_b;
  logic [6:0] diag = 7'h00;
  logic beat_en = 1'b1;
  logic task_beat = 1'b0;
  logic [3:0] beat_cnt = 4'h0;
  logic fb = 1'b1;
  logic pwm_block;
  logic torque_off_active;
  logic [15:0] fault_code;
  logic irq;
  logic [31:0] rd_val;
  logic [7:0] seed = 8'h5c;
  int n_mismatch = 0;
  int n_checks = 0;

  initial begin
    forever #2.5 clk_sys = !clk_sys;
  end
  always @(posedge clk_sys) begin
    beat_cnt <= beat_cnt + 4'h1;
    task_beat <= beat_en && beat_cnt == 4'h0;
  end

  safety_input_fault_monitor #(.TASK_TIMEOUT(50)) u_safety_input_fault_monitor (
    .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .input_ch_a(in_a),
    .input_ch_b(in_b), .torque_off_ch_a(ch_a), .torque_off_ch_b(ch_b),
    .rail_out_of_range(diag[0]), .cpu_test_fail(diag[1]), .ram_test_fail(diag[2]),
    .flash_test_fail(diag[3]), .stack_overflow(diag[4]), .task_beat(task_beat),
    .buf_supply_bad(diag[5]), .coupler_short(diag[6]), .buf_blocked_fb(fb),
    .pwm_block(pwm_block), .torque_off_active(torque_off_active),
    .fault_code(fault_code), .irq(irq));
  sto_terminal_model u_sto_terminal_model (.clk_sys(clk_sys), .drop_a(drop_a),
    .drop_b(drop_b), .chatter(chatter), .torque_off_ch_a(ch_a), .torque_off_ch_b(ch_b));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic int diag_bit(input int j);
    return (j == 0) ? FLT_RAIL : (j == 5) ? FLT_BUF_SUPPLY : (j == 6) ? FLT_COUPLER : FLT_SELF_TEST;
  endfunction
  function automatic logic [15:0] exp_code(input int b);
    case (b)
      FLT_RAIL: return CODE_RAIL;
      FLT_SELF_TEST: return CODE_SELF_TEST;
      FLT_BUF_SUPPLY: return CODE_BUF_SUPPLY;
      FLT_COUPLER: return CODE_COUPLER;
      default: return CODE_INPUT_BASE + 16'(b);
    endcase
  endfunction

  task automatic report_and_stop();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    rd(a, rd_val);
    check(rd_val, e);
  endtask
  task automatic wait_sto(input logic e);
    int k;
    k = 0;
    while (torque_off_active !== e && k < 20000) begin
      @(posedge clk_sys);
      k++;
    end
    if (k == 20000) begin
      n_mismatch++;
      $display("BAD %0t: torque off state never reached", $time);
      report_and_stop();
    end
  endtask
  task automatic do_reset();
    nrst <= 1'b0;
    wait_cyc(6);
    nrst <= 1'b1;
    wait_cyc(3);
  endtask
  task automatic drive_mis(input int i, input logic w, input int n);
    @(posedge clk_sys);
    in_a[i] <= w;
    in_b[i] <= !w;
    wait_cyc(n);
    in_a[i] <= 1'b0;
    in_b[i] <= 1'b0;
  endtask

  initial begin
    do_reset();
    rd_chk(OFS_FAULT_MASK, 32'h3fff);
    for (int i = 0; i < 5; i++) begin
      rd_chk(OFS_LIMIT_ONE + 8'(4 * i), 32'h64);
      wr(OFS_LIMIT_ONE + 8'(4 * i), 32'h3);
    end
    rd_chk(OFS_FILTER_SETTING, 32'ha);
    rd_chk(8'h2c, 32'h0);
    wr(OFS_FILTER_SETTING, 32'h1);
    wait_cyc(3000);
    wr(OFS_CONTROL, 32'h1);
    wait_sto(1'b0);
    wait_cyc(4);
    check(pwm_block, 32'h0);
    wr(OFS_FAULT_STATUS, 32'h3fff);
    rd_chk(OFS_FAULT_STATUS, 32'h0);
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      // Two short episodes under the limit must not add up
      drive_mis(i, seed[0], 2 * TICK_CYC);
      wait_cyc(TICK_CYC);
      drive_mis(i, !seed[0], 2 * TICK_CYC);
      rd_chk(OFS_FAULT_STATUS, 32'h0);
      drive_mis(i, seed[1], (6 + int'(seed[3:2])) * TICK_CYC);
      rd_chk(OFS_FAULT_STATUS, 32'h1 << i);
      check(fault_code, exp_code(i));
      wr(OFS_FAULT_STATUS, 32'h1 << i);
    end
    for (int j = 0; j < 7; j++) begin
      @(posedge clk_sys);
      diag[j] <= 1'b1;
      @(posedge clk_sys);
      diag[j] <= 1'b0;
      wait_cyc(2);
      rd_chk(OFS_FAULT_STATUS, 32'h1 << diag_bit(j));
      check(fault_code, exp_code(diag_bit(j)));
      wr(OFS_FAULT_STATUS, 32'h1 << diag_bit(j));
    end
    wr(OFS_FAULT_MASK, 32'h0);
    beat_en <= 1'b0;
    wait_cyc(60);
    beat_en <= 1'b1;
    check(irq, 32'h0);
    rd_chk(OFS_FAULT_STATUS, 32'h1 << FLT_TASK);
    check(fault_code, CODE_TASK);
    wr(OFS_FAULT_MASK, 32'h1 << FLT_TASK);
    wait_cyc(2);
    check(irq, 32'h1);
    wr(OFS_FAULT_STATUS, 32'h1 << FLT_TASK);
    wait_cyc(2);
    check(irq, 32'h0);
    wr(OFS_FAULT_MASK, 32'h3fff);
    drop_a <= 1'b1;
    wait_sto(1'b1);
    wait_cyc(2);
    check(pwm_block, 32'h1);
    rd_chk(OFS_LIVE_STATE, 32'((1 << LIVE_TORQUE_OFF) | (1 << LIVE_PWM_BLOCK)
      | (1 << LIVE_CH_B) | (1 << LIVE_INIT_DONE)));
    wait_cyc(14 * TICK_CYC);
    rd_chk(OFS_FAULT_STATUS, 32'h300);
    check(fault_code, CODE_SINGLE_CH);
    rd_chk(OFS_FAULT_CODE, 32'(CODE_SINGLE_CH));
    wr(OFS_CONTROL, 32'h1);
    wait_cyc(4);
    check(torque_off_active, 32'h1);
    drop_a <= 1'b0;
    wait_cyc(4 * TICK_CYC);
    wr(OFS_CONTROL, 32'h1);
    wait_sto(1'b0);
    wr(OFS_FAULT_STATUS, 32'h3fff);
    drop_a <= 1'b1;
    drop_b <= 1'b1;
    wait_sto(1'b1);
    wait_cyc(4);
    rd_chk(OFS_FAULT_STATUS, 32'h100);
    check(fault_code, CODE_TORQUE_OFF);
    drop_a <= 1'b0;
    drop_b <= 1'b0;
    wait_cyc(4 * TICK_CYC);
    wr(OFS_CONTROL, 32'h1);
    wait_sto(1'b0);
    chatter <= 1'b1;
    wait_cyc(400);
    chatter <= 1'b0;
    wait_cyc(4);
    rd(OFS_FAULT_STATUS, rd_val);
    check(rd_val[FLT_NOISE], 32'h1);
    check(fault_code, CODE_NOISE);
    // Second power-up with a buffer that cannot block
    fb <= 1'b0;
    do_reset();
    wait_cyc(BUF_TEST_CYC + 20);
    rd(OFS_FAULT_STATUS, rd_val);
    check(rd_val[FLT_BUF_INIT], 32'h1);
    check(pwm_block, 32'h1);
    report_and_stop();
  end
endmodule // safety_input_fault_monitor_test

bind safety_input_fault_monitor fault_mon_checker u_fault_mon_checker (
  .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .torque_off_ch_a(torque_off_ch_a), .torque_off_ch_b(torque_off_ch_b),
  .pwm_block(pwm_block), .torque_off_active(torque_off_active),
  .fault_code(fault_code), .irq(irq));
